// ===== inc/dcb_pkg.sv
// constants for the disk command block register bank
package dcb_pkg;
  // configuration indices
  localparam logic [5:0]  CFG_MEMORY      = 6'h00;
  localparam logic [5:0]  CFG_IO_CONTIG   = 6'h01;
  localparam logic [5:0]  CFG_PRIMARY     = 6'h02;
  localparam logic [5:0]  CFG_SECONDARY   = 6'h03;
  localparam int          CFG_IDX_W       = 6;
  // legacy io windows (address bits 10..3 for command, 10..1 for control)
  localparam logic [10:0] PRI_CMD_BASE    = 11'h1f0;
  localparam logic [10:0] PRI_CTL_BASE    = 11'h3f6;
  localparam logic [10:0] SEC_CMD_BASE    = 11'h170;
  localparam logic [10:0] SEC_CTL_BASE    = 11'h376;
  localparam logic [10:0] MEM_ALT_BASE    = 11'h400;
  localparam int          PRI_IRQ_LINE    = 14;
  // task file offsets inside a window
  localparam logic [2:0]  TF_DATA         = 3'h0;
  localparam logic [2:0]  TF_ERR_FEAT     = 3'h1;
  localparam logic [2:0]  TF_COUNT        = 3'h2;
  localparam logic [2:0]  TF_SECTOR       = 3'h3;
  localparam logic [2:0]  TF_CYL_LOW      = 3'h4;
  localparam logic [2:0]  TF_CYL_HIGH     = 3'h5;
  // error flag bit positions
  localparam int          ERR_BAD_BLOCK   = 7;
  localparam int          ERR_UNCORR      = 6;
  localparam int          ERR_MEDIA_CHG   = 5;
  localparam int          ERR_ID_MISSING  = 4;
  localparam int          ERR_CHG_REQ     = 3;
  localparam int          ERR_ABORTED     = 2;
  localparam int          ERR_TRK0_MISS   = 1;
  localparam int          ERR_AMARK_MISS  = 0;
  // reset values
  localparam logic [7:0]  TF_RESET_BYTE   = 8'h00;
  localparam logic [7:0]  COUNT_RESET     = 8'h01;
  localparam logic [7:0]  SECTOR_RESET    = 8'h01;
  localparam int          FIFO_DEPTH      = 32;
  localparam int          DATA_W          = 16;
endpackage

// ===== src/dcb_fifo.sv
// parameterised flip-flop fifo with valid/ready on both sides
`timescale 1ns/100ps
`default_nettype none
module dcb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic             sys_clk_i,
  input  wire logic             rst_n_i,
  // fill side
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // drain side
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o,
  // level
  output var  logic [$clog2(DEPTH):0] level_o
);
  localparam int AW = $clog2(DEPTH);

  // pointer arithmetic relies on power of two wrap
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("dcb_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;
  wire              push;
  wire              pop;
  wire              full;
  wire              empty;

  // honest full and empty from extended pointers
  assign full        = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
                       (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);
  assign empty       = (wr_ptr_reg == rd_ptr_reg);
  assign push        = in_valid_i && !full;
  assign pop         = out_ready_i && !empty;
  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = mem_reg[rd_ptr_reg[AW-1:0]];
  assign level_o     = wr_ptr_reg - rd_ptr_reg;

  // storage write, no reset needed on data
  always_ff @(posedge sys_clk_i)
  begin
    if (push)
    begin
      mem_reg[wr_ptr_reg[AW-1:0]] <= in_data_i;
    end
  end

  // pointers
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ===== src/dcb_task_file.sv
// task-file register bank with mapping decode and sector data fifo
`timescale 1ns/100ps
`default_nettype none
module dcb_task_file
  import dcb_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rst_n_i,
  // card bus from host, one cycle strobes
  input  wire logic [10:0] host_addr_i,
  input  wire logic        host_iorq_i,
  input  wire logic        host_memrq_i,
  input  wire logic        host_rd_i,
  input  wire logic        host_wr_i,
  input  wire logic        host_ce1_n_i,
  input  wire logic        host_ce2_n_i,
  input  wire logic [15:0] host_wdata_i,
  output logic      [15:0] host_rdata_o,
  output logic             host_rdata_oe_o,
  // configuration option register access and soft reset
  input  wire logic        cfg_wr_i,
  input  wire logic [7:0]  cfg_wdata_i,
  output logic      [5:0]  cfg_index_o,
  output logic             io_mode_o,
  // drive side: command completion and buffer
  input  wire logic        cmd_done_i,
  input  wire logic [7:0]  done_count_i,
  input  wire logic [7:0]  done_sector_i,
  input  wire logic [7:0]  done_cyl_low_i,
  input  wire logic [7:0]  done_cyl_high_i,
  input  wire logic        err_load_i,
  input  wire logic [7:0]  err_flags_i,
  input  wire logic        drv_wr_valid_i,
  output logic             drv_wr_ready_o,
  input  wire logic [15:0] drv_wr_data_i,
  output logic             drv_rd_valid_o,
  input  wire logic        drv_rd_ready_i,
  output logic      [15:0] drv_rd_data_o,
  // task file contents toward the drive
  output logic      [7:0]  feature_o,
  output logic      [7:0]  count_o,
  output logic      [7:0]  sector_o,
  output logic      [7:0]  cyl_low_o,
  output logic      [7:0]  cyl_high_o,
  output logic      [7:0]  err_flags_o
);
  if (DEPTH < 2) begin : g_bad_depth
    $error("dcb_task_file fifo depth too small");
  end

  // registers
  logic [5:0]  cfg_index_reg;
  logic [7:0]  feature_reg;
  logic [7:0]  count_reg;
  logic [7:0]  sector_reg;
  logic [7:0]  cyl_low_reg;
  logic [7:0]  cyl_high_reg;
  logic [7:0]  err_reg;
  logic [15:0] rdata_reg;
  logic        rdata_oe_reg;
  logic [7:0]  h2d_low_reg;
  logic        h2d_half_reg;
  logic        d2h_half_reg;
  logic [15:0] h2d_word_reg;
  logic        h2d_valid_reg;
  logic        io_mode_reg;

  // window decode per selected mapping
  wire         soft_reset;
  wire         card_sel;
  wire         mem_hit;
  wire         contig_hit;
  wire         pri_cmd_hit;
  wire         pri_ctl_hit;
  wire         sec_cmd_hit;
  wire         sec_ctl_hit;
  wire         tf_hit;
  wire [2:0]   tf_off;
  wire         odd_byte;
  wire         word_acc;
  wire         hi_lane;
  wire         rd_acc;
  wire         wr_acc;

  // soft reset is bit 7 of the option byte; index in low six bits
  assign soft_reset  = cfg_wr_i && cfg_wdata_i[7];
  assign card_sel    = !host_ce1_n_i || !host_ce2_n_i;
  // memory window: index zero only, no memory decode at any other index value
  assign mem_hit     = (cfg_index_reg == CFG_MEMORY) && host_memrq_i &&
                       ((host_addr_i[10:4] == 7'h00) || host_addr_i[10]);
  assign contig_hit  = (cfg_index_reg == CFG_IO_CONTIG) && host_iorq_i;
  assign pri_cmd_hit = (cfg_index_reg == CFG_PRIMARY) && host_iorq_i &&
                       (host_addr_i[10:3] == PRI_CMD_BASE[10:3]);
  assign pri_ctl_hit = (cfg_index_reg == CFG_PRIMARY) && host_iorq_i &&
                       (host_addr_i[10:1] == PRI_CTL_BASE[10:1]);
  assign sec_cmd_hit = (cfg_index_reg == CFG_SECONDARY) && host_iorq_i &&
                       (host_addr_i[10:3] == SEC_CMD_BASE[10:3]);
  assign sec_ctl_hit = (cfg_index_reg == CFG_SECONDARY) && host_iorq_i &&
                       (host_addr_i[10:1] == SEC_CTL_BASE[10:1]);
  // control pair holds no task-file byte here; it answers but reads zero
  assign tf_hit      = card_sel && (mem_hit || contig_hit || pri_cmd_hit || sec_cmd_hit);
  // same low offsets in every mapping
  assign tf_off      = host_addr_i[2:0];
  // ce1 low with ce2 low is a word; ce2 alone selects the odd byte on d15..8
  assign word_acc    = !host_ce1_n_i && !host_ce2_n_i;
  assign hi_lane     = host_ce1_n_i && !host_ce2_n_i;
  assign odd_byte    = hi_lane || (host_addr_i[0] && !word_acc);
  assign rd_acc      = tf_hit && host_rd_i;
  assign wr_acc      = tf_hit && host_wr_i;

  // data port access and byte order
  wire         data_acc;
  wire         data_rd;
  wire         data_wr;
  wire         d2h_valid;
  wire [15:0]  d2h_data;
  wire         d2h_pop;
  wire         h2d_ready;
  wire [7:0]   sel_byte;
  wire [7:0]   d2h_byte;

  assign data_acc  = tf_off[2:1] == 2'b00 && tf_off[0] == 1'b0;
  assign data_rd   = rd_acc && data_acc;
  assign data_wr   = wr_acc && data_acc && !h2d_valid_reg;
  // byte reads drain a word on the second byte, low byte first
  assign d2h_pop   = data_rd && d2h_valid && (word_acc || d2h_half_reg);
  assign d2h_byte  = d2h_half_reg ? d2h_data[15:8] : d2h_data[7:0];
  assign sel_byte  = hi_lane ? host_wdata_i[15:8] : host_wdata_i[7:0];

  // sector data out of the drive toward the host
  dcb_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_d2h_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i && !soft_reset),
    .in_valid_i  (drv_wr_valid_i),
    .in_ready_o  (drv_wr_ready_o),
    .in_data_i   (drv_wr_data_i),
    .out_valid_o (d2h_valid),
    .out_ready_i (d2h_pop),
    .out_data_o  (d2h_data),
    .level_o     ()
  );

  // host data into the drive; staging word stalls while fifo is full
  dcb_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (DEPTH)
  ) u_h2d_fifo (
    .sys_clk_i   (sys_clk_i),
    .rst_n_i     (rst_n_i && !soft_reset),
    .in_valid_i  (h2d_valid_reg),
    .in_ready_o  (h2d_ready),
    .in_data_i   (h2d_word_reg),
    .out_valid_o (drv_rd_valid_o),
    .out_ready_i (drv_rd_ready_i),
    .out_data_o  (drv_rd_data_o),
    .level_o     ()
  );

  // configuration index; all resets go back to memory mapping
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      cfg_index_reg <= CFG_MEMORY;
      io_mode_reg   <= 1'b0;
    end
    else if (cfg_wr_i)
    begin
      cfg_index_reg <= cfg_wdata_i[CFG_IDX_W-1:0];
      io_mode_reg   <= cfg_wdata_i[CFG_IDX_W-1:0] != CFG_MEMORY;
    end
  end

  // host word assembly; a full staging word waits for fifo room
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      h2d_low_reg   <= TF_RESET_BYTE;
      h2d_half_reg  <= 1'b0;
      h2d_word_reg  <= 16'h0000;
      h2d_valid_reg <= 1'b0;
    end
    else
    begin
      if (h2d_valid_reg && h2d_ready)
      begin
        h2d_valid_reg <= 1'b0;
      end
      if (data_wr && word_acc)
      begin
        h2d_word_reg  <= host_wdata_i;
        h2d_valid_reg <= 1'b1;
      end
      else if (data_wr && !h2d_half_reg)
      begin
        h2d_low_reg  <= sel_byte;
        h2d_half_reg <= 1'b1;
      end
      else if (data_wr)
      begin
        h2d_word_reg  <= {sel_byte, h2d_low_reg};
        h2d_valid_reg <= 1'b1;
        h2d_half_reg  <= 1'b0;
      end
    end
  end

  // byte read phase toggles per byte read of the data port
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      d2h_half_reg <= 1'b0;
    end
    else if (data_rd && d2h_valid && !word_acc)
    begin
      d2h_half_reg <= !d2h_half_reg;
    end
  end

  // task file writes from host; completion overrides a same-cycle write
  wire wr_odd_reg;
  wire [2:0] wr_off;
  wire [7:0] wr_byte;
  // odd register reached by a byte on either lane; word writes load the even one
  assign wr_off     = odd_byte ? {tf_off[2:1], 1'b1} : tf_off;
  assign wr_byte    = (odd_byte && word_acc) || hi_lane ?
                      host_wdata_i[15:8] : host_wdata_i[7:0];
  assign wr_odd_reg = wr_acc && !data_acc;

  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      feature_reg  <= TF_RESET_BYTE;
      count_reg    <= COUNT_RESET;
      sector_reg   <= SECTOR_RESET;
      cyl_low_reg  <= TF_RESET_BYTE;
      cyl_high_reg <= TF_RESET_BYTE;
    end
    else if (cmd_done_i)
    begin
      count_reg    <= done_count_i;
      sector_reg   <= done_sector_i;
      cyl_low_reg  <= done_cyl_low_i;
      cyl_high_reg <= done_cyl_high_i;
    end
    else if (wr_odd_reg)
    begin
      unique case (wr_off)
        TF_ERR_FEAT: feature_reg  <= wr_byte;
        TF_COUNT:    count_reg    <= wr_byte;
        TF_SECTOR:   sector_reg   <= wr_byte;
        TF_CYL_LOW:  cyl_low_reg  <= wr_byte;
        TF_CYL_HIGH: cyl_high_reg <= wr_byte;
        default:     ;
      endcase
    end
  end

  // error flags loaded only by the drive, never by host writes
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i || soft_reset)
    begin
      err_reg <= TF_RESET_BYTE;
    end
    else if (err_load_i)
    begin
      err_reg <= err_flags_i;
    end
  end

  // read mux; feature is write-only so offset 1 returns error flags
  wire [7:0]  rd_byte;
  wire [15:0] rd_word;
  wire [2:0]  rd_off;
  assign rd_off  = odd_byte ? {tf_off[2:1], 1'b1} : tf_off;
  assign rd_byte = (rd_off == TF_ERR_FEAT) ? err_reg :
                   (rd_off == TF_COUNT)    ? count_reg :
                   (rd_off == TF_SECTOR)   ? sector_reg :
                   (rd_off == TF_CYL_LOW)  ? cyl_low_reg :
                   (rd_off == TF_CYL_HIGH) ? cyl_high_reg : 8'h00;
  assign rd_word = data_acc ? (word_acc ? d2h_data : {d2h_byte, d2h_byte}) :
                   word_acc ? {(tf_off == TF_COUNT) ? sector_reg :
                               (tf_off == TF_CYL_LOW) ? cyl_high_reg :
                               (tf_off == TF_DATA) ? err_reg : 8'h00, rd_byte} :
                   {rd_byte, rd_byte};

  // registered read data, driven the cycle after the strobe
  always_ff @(posedge sys_clk_i)
  begin
    if (!rst_n_i)
    begin
      rdata_reg    <= 16'h0000;
      rdata_oe_reg <= 1'b0;
    end
    else
    begin
      rdata_reg    <= rd_acc ? rd_word : 16'h0000;
      rdata_oe_reg <= rd_acc || (card_sel && host_rd_i && (pri_ctl_hit || sec_ctl_hit));
    end
  end

  // outputs straight from flip-flops
  assign host_rdata_o    = rdata_reg;
  assign host_rdata_oe_o = rdata_oe_reg;
  assign cfg_index_o     = cfg_index_reg;
  assign io_mode_o       = io_mode_reg;
  assign feature_o       = feature_reg;
  assign count_o         = count_reg;
  assign sector_o        = sector_reg;
  assign cyl_low_o       = cyl_low_reg;
  assign cyl_high_o      = cyl_high_reg;
  assign err_flags_o     = err_reg;
endmodule
`default_nettype wire

// ===== test/dcb_task_file_asserts.sv
// concurrent checks for the task-file register bank ports
`timescale 1ns/100ps
`default_nettype none
module dcb_task_file_asserts
  import dcb_pkg::*;
(
  // clock and reset
  input wire logic        sys_clk_i,
  input wire logic        rst_n_i,
  // card bus
  input wire logic [10:0] host_addr_i,
  input wire logic        host_iorq_i,
  input wire logic        host_memrq_i,
  input wire logic        host_rd_i,
  input wire logic        host_wr_i,
  input wire logic        host_ce1_n_i,
  input wire logic        host_ce2_n_i,
  input wire logic [15:0] host_wdata_i,
  input wire logic [15:0] host_rdata_o,
  input wire logic        host_rdata_oe_o,
  // option register
  input wire logic        cfg_wr_i,
  input wire logic [7:0]  cfg_wdata_i,
  input wire logic [5:0]  cfg_index_o,
  input wire logic        io_mode_o,
  // drive side
  input wire logic        cmd_done_i,
  input wire logic [7:0]  done_count_i,
  input wire logic [7:0]  done_sector_i,
  input wire logic [7:0]  done_cyl_low_i,
  input wire logic [7:0]  done_cyl_high_i,
  input wire logic        err_load_i,
  input wire logic [7:0]  err_flags_i,
  // task file contents
  input wire logic [7:0]  feature_o,
  input wire logic [7:0]  count_o,
  input wire logic [7:0]  sector_o,
  input wire logic [7:0]  cyl_low_o,
  input wire logic [7:0]  cyl_high_o,
  input wire logic [7:0]  err_flags_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // independent window decode; unknown indices answer nothing
  wire sel_w  = !(host_ce1_n_i && host_ce2_n_i);
  wire lo_w   = !host_ce1_n_i && host_ce2_n_i;
  wire pri_w  = host_iorq_i && (host_addr_i[10:3] == 8'h3e || host_addr_i[10:1] == 10'h1fb);
  wire sec_w  = host_iorq_i && (host_addr_i[10:3] == 8'h2e || host_addr_i[10:1] == 10'h1bb);
  wire mem_w  = host_memrq_i && (host_addr_i[10:4] == 7'h00 || host_addr_i[10]);
  wire srst_w = cfg_wr_i && cfg_wdata_i[7];
  wire hit_w  = sel_w && (cfg_index_o == CFG_MEMORY    ? mem_w :
                          cfg_index_o == CFG_IO_CONTIG ? host_iorq_i :
                          cfg_index_o == CFG_PRIMARY   ? pri_w :
                          cfg_index_o == CFG_SECONDARY ? sec_w : 1'b0);

  chk_read_answer: assert property (host_rd_i && hit_w |=> host_rdata_oe_o)
    else $error("decoded read not answered");
  chk_quiet_bus: assert property (!(host_rd_i && hit_w) |=> !host_rdata_oe_o)
    else $error("bus driven without a decoded read");
  chk_mode_flag: assert property (io_mode_o == (cfg_index_o != CFG_MEMORY))
    else $error("io mode flag disagrees with index");
  chk_index_load: assert property (cfg_wr_i && !cfg_wdata_i[7] |=> cfg_index_o == $past(cfg_wdata_i[5:0]))
    else $error("index not taken from option byte");
  chk_soft_reset: assert property (srst_w |=> cfg_index_o == CFG_MEMORY && count_o == COUNT_RESET)
    else $error("soft reset left mapping or count");
  chk_err_hold: assert property (!err_load_i && !srst_w |=> $stable(err_flags_o))
    else $error("error flags moved without a load");
  chk_err_load: assert property (err_load_i && !srst_w |=> err_flags_o == $past(err_flags_i))
    else $error("error flags not loaded");
  chk_done_load: assert property (cmd_done_i && !srst_w |=> {count_o, sector_o, cyl_low_o, cyl_high_o} == $past({done_count_i, done_sector_i, done_cyl_low_i, done_cyl_high_i}))
    else $error("final values not loaded");
  chk_err_read: assert property (host_rd_i && hit_w && lo_w && host_addr_i[3:0] == 4'h1 ##1 !err_load_i |-> host_rdata_o[7:0] == $past(err_flags_o))
    else $error("error read returns wrong flags");
  chk_feature_write: assert property (host_wr_i && hit_w && lo_w && host_addr_i[3:0] == 4'h1 && !cmd_done_i && !srst_w |=> feature_o == $past(host_wdata_i[7:0]))
    else $error("feature byte not written");
  chk_upper_lane: assert property (host_wr_i && hit_w && !host_ce2_n_i && host_ce1_n_i && host_addr_i[3:0] == 4'h2 && !cmd_done_i && !srst_w |=> sector_o == $past(host_wdata_i[15:8]))
    else $error("upper lane write missed odd register");

  cover property (host_rd_i && hit_w ##1 host_rdata_oe_o);
  cover property (cmd_done_i);
  cover property (srst_w);
endmodule
bind dcb_task_file dcb_task_file_asserts i_dcb_task_file_asserts (.sys_clk_i, .rst_n_i,
  .host_addr_i, .host_iorq_i, .host_memrq_i, .host_rd_i, .host_wr_i, .host_ce1_n_i,
  .host_ce2_n_i, .host_wdata_i, .host_rdata_o, .host_rdata_oe_o, .cfg_wr_i, .cfg_wdata_i,
  .cfg_index_o, .io_mode_o, .cmd_done_i, .done_count_i, .done_sector_i, .done_cyl_low_i,
  .done_cyl_high_i, .err_load_i, .err_flags_i, .feature_o, .count_o, .sector_o, .cyl_low_o,
  .cyl_high_o, .err_flags_o);
`default_nettype wire

// ===== test/dcb_host_model.sv
// host socket model making card bus and option register accesses
`timescale 1ns/100ps
`default_nettype none
module dcb_host_model (
  // clock
  input  wire logic        sys_clk_i,
  // card bus
  output var  logic [10:0] addr_o,
  output var  logic        iorq_o,
  output var  logic        memrq_o,
  output var  logic        rd_o,
  output var  logic        wr_o,
  output var  logic        ce1_n_o,
  output var  logic        ce2_n_o,
  output var  logic [15:0] wdata_o,
  input  wire logic [15:0] rdata_i,
  input  wire logic        oe_i,
  // option register
  output var  logic        cfg_wr_o,
  output var  logic [7:0]  cfg_wdata_o
);
  // idle bus at time zero
  initial
  begin
    {iorq_o, memrq_o, rd_o, wr_o, cfg_wr_o, ce1_n_o, ce2_n_o} = 7'h03;
    {addr_o, wdata_o, cfg_wdata_o} = '0;
  end

  // one-edge strobe; released lines are inverted so stale values cannot pass
  task automatic acc(input logic w, input logic io, input logic [10:0] a,
                     input logic [1:0] cen, input logic [15:0] d,
                     output logic [15:0] q, output logic oe);
    @(posedge sys_clk_i);
    #1 {addr_o, iorq_o, memrq_o, rd_o, wr_o, wdata_o} = {a, io, !io, !w, w, d};
    {ce2_n_o, ce1_n_o} = cen;
    @(posedge sys_clk_i);
    #1 {iorq_o, memrq_o, rd_o, wr_o, ce2_n_o, ce1_n_o} = 6'h03;
    {addr_o, wdata_o} = {~a, ~d};
    q = rdata_i;
    oe = oe_i;
  endtask

  // option byte: index in the low six bits, bit 7 soft reset
  task automatic cfg(input logic [7:0] b);
    @(posedge sys_clk_i);
    #1 {cfg_wr_o, cfg_wdata_o} = {1'b1, b};
    @(posedge sys_clk_i);
    #1 {cfg_wr_o, cfg_wdata_o} = {1'b0, ~b};
  endtask
endmodule
`default_nettype wire

// ===== test/test_disk_command_block_regs.sv
// self-checking bench for the task-file register bank
`timescale 1ns/100ps
`default_nettype none
module test_disk_command_block_regs;
  import dcb_pkg::*;
  localparam int DP = 4;
  // stimulus and observed nets
  logic        sys_clk_i, rst_n_i, cmd_done_i, err_load_i, drv_wr_valid_i, drv_rd_ready_i;
  logic [7:0]  done_count_i, done_sector_i, done_cyl_low_i, done_cyl_high_i, err_flags_i;
  logic [15:0] drv_wr_data_i, q, v;
  wire  [10:0] host_addr_i;
  wire  [15:0] host_wdata_i, host_rdata_o, drv_rd_data_o;
  wire         host_iorq_i, host_memrq_i, host_rd_i, host_wr_i, host_ce1_n_i, host_ce2_n_i;
  wire         host_rdata_oe_o, cfg_wr_i, io_mode_o, drv_wr_ready_o, drv_rd_valid_o;
  wire  [7:0]  cfg_wdata_i, feature_o, count_o, sector_o, cyl_low_o, cyl_high_o, err_flags_o;
  wire  [5:0]  cfg_index_o;
  logic        oe;
  logic [15:0] exp_q [$];
  logic [7:0]  dv [4];
  int          fails = 0, samples_checked = 0, n;
  // {index, io, answers, 0, address}
  logic [15:0] dec [11] = '{16'h21f2, 16'h1002, 16'h1402, 16'h72a2, 16'h4002, 16'hb1f2,
                            16'hb3f6, 16'ha172, 16'hf172, 16'hf376, 16'he1f2};

  dcb_task_file #(.DEPTH(DP)) i_dcb_task_file (.sys_clk_i, .rst_n_i, .host_addr_i,
    .host_iorq_i, .host_memrq_i, .host_rd_i, .host_wr_i, .host_ce1_n_i, .host_ce2_n_i,
    .host_wdata_i, .host_rdata_o, .host_rdata_oe_o, .cfg_wr_i, .cfg_wdata_i, .cfg_index_o,
    .io_mode_o, .cmd_done_i, .done_count_i, .done_sector_i, .done_cyl_low_i, .done_cyl_high_i,
    .err_load_i, .err_flags_i, .drv_wr_valid_i, .drv_wr_ready_o, .drv_wr_data_i,
    .drv_rd_valid_o, .drv_rd_ready_i, .drv_rd_data_o, .feature_o, .count_o, .sector_o,
    .cyl_low_o, .cyl_high_o, .err_flags_o);
  dcb_host_model i_dcb_host_model (.sys_clk_i, .addr_o(host_addr_i), .iorq_o(host_iorq_i),
    .memrq_o(host_memrq_i), .rd_o(host_rd_i), .wr_o(host_wr_i), .ce1_n_o(host_ce1_n_i),
    .ce2_n_o(host_ce2_n_i), .wdata_o(host_wdata_i), .rdata_i(host_rdata_o),
    .oe_i(host_rdata_oe_o), .cfg_wr_o(cfg_wr_i), .cfg_wdata_o(cfg_wdata_i));

  // clock and watchdog
  initial
  begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  initial
  begin
    #200000 fails++;
    tally_and_finish();
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // io read in the current mapping, masked compare of the lanes that matter
  task automatic rdc(input logic [10:0] a, input logic [1:0] cen, input logic [15:0] m,
                     input logic [15:0] e, input string nm);
    i_dcb_host_model.acc(1'b0, 1'b1, a, cen, 16'h0000, q, oe);
    chk(nm, {oe, q & m}, {1'b1, e & m});
  endtask

  task automatic wrb(input logic [10:0] a, input logic [1:0] cen, input logic [15:0] d);
    i_dcb_host_model.acc(1'b1, 1'b1, a, cen, d, q, oe);
  endtask

  function automatic logic [7:0] tf_out(input int o);
    return o == 2 ? count_o : o == 3 ? sector_o : o == 4 ? cyl_low_o : cyl_high_o;
  endfunction

  // drive side pops one host word; stalls until asked
  task automatic pop();
    n = 0;
    while (drv_rd_valid_o !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk_i);
      #1 n++;
    end
    if (n == 20)
    begin
      fails++;
      tally_and_finish();
    end
    chk("fifo word", drv_rd_data_o, exp_q.pop_front());
    drv_rd_ready_i = 1'b1;
    @(posedge sys_clk_i);
    #1 drv_rd_ready_i = 1'b0;
    // idle edge so a following pop never lowers and raises ready together
    @(posedge sys_clk_i);
    #1;
  endtask

  // main sequence
  initial
  begin
    {cmd_done_i, err_load_i, drv_wr_valid_i, drv_rd_ready_i, rst_n_i, drv_wr_data_i} = '0;
    {done_count_i, done_sector_i, done_cyl_low_i, done_cyl_high_i, err_flags_i} = '0;
    repeat (6) @(posedge sys_clk_i);
    #1 rst_n_i = 1'b1;
    chk("reset", {cfg_index_o, count_o, sector_o, err_flags_o}, {CFG_MEMORY, 24'h010100});
    void'($urandom(32'hdbae));
    foreach (dec[i])
    begin
      i_dcb_host_model.cfg({6'h00, dec[i][15:14]});
      i_dcb_host_model.acc(1'b0, dec[i][13], dec[i][10:0], 2'b10, 16'h0000, q, oe);
      chk("window", oe, dec[i][12]);
      if (dec[i][12] && dec[i][2:0] == TF_COUNT)
        chk("count", q[7:0], COUNT_RESET);
    end
    wrb(11'h172, 2'b10, 16'h005a);
    i_dcb_host_model.cfg(8'h83);
    chk("soft reset", {io_mode_o, cfg_index_o, count_o}, {1'b0, CFG_MEMORY, COUNT_RESET});
    i_dcb_host_model.cfg({2'b00, CFG_PRIMARY});
    chk("io mode", io_mode_o, 1'b1);
    $display("test decode done");
    for (int o = 2; o < 6; o++)
    begin
      dv[o-2] = 8'($urandom);
      wrb(PRI_CMD_BASE + 11'(o), 2'b10, {~dv[o-2], dv[o-2]});
      chk("tf write", tf_out(o), dv[o-2]);
      dv[o-2] = 8'($urandom);
    end
    {done_count_i, done_sector_i, done_cyl_low_i, done_cyl_high_i} = {dv[0], dv[1], dv[2], dv[3]};
    cmd_done_i = 1'b1;
    @(posedge sys_clk_i);
    #1 cmd_done_i = 1'b0;
    for (int o = 2; o < 6; o++)
      rdc(PRI_CMD_BASE + 11'(o), 2'b10, 16'h00ff, {8'h00, dv[o-2]}, "tf final");
    v = 16'($urandom);
    wrb(11'h1f2, 2'b01, {v[7:0], ~v[7:0]});
    chk("upper lane write", sector_o, v[7:0]);
    rdc(11'h1f2, 2'b01, 16'hff00, {v[7:0], 8'h00}, "upper lane read");
    $display("test task file done");
    for (int b = 0; b < 8; b++)
    begin
      err_flags_i = 8'h01 << b;
      err_load_i = 1'b1;
      @(posedge sys_clk_i);
      #1 err_load_i = 1'b0;
      rdc(11'h1f1, 2'b10, 16'h00ff, {8'h00, err_flags_i}, "error flag");
    end
    v[7:0] = ~err_flags_i;
    wrb(11'h1f1, 2'b10, {8'h00, v[7:0]});
    chk("feature", feature_o, v[7:0]);
    chk("error kept", err_flags_o, 8'h80);
    $display("test error feature done");
    for (int k = 0; k < DP; k++)
    begin
      v = 16'($urandom);
      exp_q.push_back(v);
      wrb(11'h1f0, 2'b00, v);
    end
    repeat (DP) pop();
    v = 16'($urandom);
    wrb(11'h1f0, 2'b10, {8'h00, v[7:0]});
    wrb(11'h1f0, 2'b10, {8'h00, v[15:8]});
    exp_q.push_back(v);
    pop();
    chk("drained", drv_rd_valid_o, 1'b0);
    n = 0;
    while (drv_wr_ready_o === 1'b1 && n < 40)
    begin
      drv_wr_data_i = 16'($urandom);
      drv_wr_valid_i = 1'b1;
      exp_q.push_back(drv_wr_data_i);
      @(posedge sys_clk_i);
      #1 n++;
    end
    drv_wr_valid_i = 1'b0;
    chk("fill count", n, DP);
    repeat (DP) rdc(11'h1f0, 2'b00, 16'hffff, exp_q.pop_front(), "host word");
    chk("empty again", drv_wr_ready_o, 1'b1);
    drv_wr_data_i = 16'($urandom);
    drv_wr_valid_i = 1'b1;
    @(posedge sys_clk_i);
    #1 drv_wr_valid_i = 1'b0;
    rdc(11'h1f0, 2'b10, 16'h00ff, drv_wr_data_i, "byte read low");
    rdc(11'h1f0, 2'b10, 16'h00ff, {8'h00, drv_wr_data_i[15:8]}, "byte read high");
    $display("test data port done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
